// File: hdl/sod_diag.sv
// Status lamps, safe output and bus diagnostics of the safe output slave
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module sod_diag
    import sod_pkg::*;
#(
    parameter int LONG_CYCLES = 32'(SOD_LONG_FAULT_CYCLES),
    parameter int SLOW_HALF   = 32'(SOD_SLOW_FLASH_CYCLES),
    parameter int FAST_HALF   = 32'(SOD_FAST_FLASH_CYCLES)
) (
    // Clock, reset and enable
    input  wire logic            clk_in,
    input  wire logic            rst_n_in,
    input  wire logic            ce_in,
    // APB slave
    input  wire sod_apb_req_type apb_in,
    output sod_apb_rsp_type      apb_out,
    // Device conditions
    input  wire logic            aux_ok_in,
    input  wire logic [2:0]      std_input_in,
    input  wire logic            enable_valid_in,
    input  wire logic            comm_fault_in,
    input  wire logic            help_reset_in,
    input  wire logic            help_restart_in,
    input  wire logic            addr_run_in,
    input  wire logic            device_error_in,
    input  wire logic            out_overload_in,
    input  wire logic            sensor_overload_in,
    // Outputs
    output sod_lamp_type         lamp_out,
    output logic                 safe_output_out,
    output logic [1:0]           std_output_out,
    output logic [3:0]           slave_input_data_out,
    output logic                 periph_error_out
);

    typedef struct packed {
        logic [1:0]      std_out_bits;
        logic            functional_switch_output_bit;
        logic            functional_switch_param;
        sod_apb_rsp_type rsp;
        sod_lamp_type    lamp;
        logic            safe_out;
        logic [1:0]      std_out;
        logic [3:0]      in_data;
        logic            perr;
    } sod_state_type;

    sod_state_type state;
    sod_state_type next_state;

    logic pending;
    logic need_reset;
    logic slow;
    logic fast;

    sod_fault_track #(
        .LONG_CYCLES     (LONG_CYCLES)
    ) u_track (
        .clk_in          (clk_in),
        .rst_n_in        (rst_n_in),
        .ce_in           (ce_in),
        .comm_fault_in   (comm_fault_in),
        .help_reset_in   (help_reset_in),
        .help_restart_in (help_restart_in),
        .pending_out     (pending),
        .need_reset_out  (need_reset)
    );

    sod_flash #(
        .SLOW_HALF (SLOW_HALF),
        .FAST_HALF (FAST_HALF)
    ) u_flash (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .ce_in     (ce_in),
        .slow_out  (slow),
        .fast_out  (fast)
    );

    logic        normal;
    logic        safe_on;
    logic        setup;
    logic        access;
    logic [31:0] status_word;

    always_comb begin
        normal  = addr_run_in && !device_error_in && !pending;
        safe_on = normal && enable_valid_in &&
                  (state.functional_switch_param ||
                   state.functional_switch_output_bit);
        setup   = apb_in.psel && !apb_in.penable;
        access  = apb_in.psel && apb_in.penable && state.rsp.pready;
        status_word = 32'h0;
        status_word[SOD_STAT_INPUT_LSB +: 3] = state.in_data[2:0];
        status_word[SOD_STAT_FOURTH]   = state.in_data[3];
        status_word[SOD_STAT_PERR]     = state.perr;
        status_word[SOD_STAT_PENDING]  = pending;
        status_word[SOD_STAT_NEED_RST] = need_reset;
        status_word[SOD_STAT_SAFE_OUT] = state.safe_out;
        status_word[SOD_STAT_AUX_OK]   = state.lamp.aux;
    end

    always_comb begin
        next_state = state;
        // Bus slave: answer in the first access cycle
        next_state.rsp.pready  = setup;
        next_state.rsp.pslverr = 1'b0;
        next_state.rsp.prdata  = 32'h0;
        if (setup) begin
            unique case (apb_in.paddr)
                SOD_CTRL_ADDR: begin
                    next_state.rsp.prdata[SOD_CTRL_STD_OUT_LSB +: 2] =
                        state.std_out_bits;
                    next_state.rsp.prdata[SOD_CTRL_FSW_OUT_BIT] =
                        state.functional_switch_output_bit;
                    next_state.rsp.prdata[SOD_CTRL_FSW_PARAM] =
                        state.functional_switch_param;
                end
                SOD_STATUS_ADDR: begin
                    next_state.rsp.prdata = status_word;
                end
                default: begin
                    next_state.rsp.pslverr = 1'b1;
                end
            endcase
        end else begin
            next_state.rsp.pslverr = 1'b0;
        end
        if (!setup && state.rsp.pready) begin
            next_state.rsp.prdata  = state.rsp.prdata;
            next_state.rsp.pslverr = state.rsp.pslverr;
        end
        if (access && apb_in.pwrite && apb_in.paddr == SOD_CTRL_ADDR) begin
            next_state.std_out_bits =
                apb_in.pwdata[SOD_CTRL_STD_OUT_LSB +: 2];
            next_state.functional_switch_output_bit =
                apb_in.pwdata[SOD_CTRL_FSW_OUT_BIT];
            next_state.functional_switch_param =
                apb_in.pwdata[SOD_CTRL_FSW_PARAM];
        end

        // Standard I/O and its lamps
        next_state.lamp.aux      = aux_ok_in;
        next_state.lamp.in_lamp  = std_input_in;
        next_state.std_out       = out_overload_in ? 2'h0 :
                                   state.std_out_bits;
        next_state.lamp.out_lamp = next_state.std_out;

        // Safe output and its lamps
        next_state.safe_out = safe_on;
        if (device_error_in) begin
            next_state.lamp.fault  = fast;
            next_state.lamp.enable = fast;
            next_state.lamp.safe   = fast;
        end else if (!addr_run_in) begin
            next_state.lamp.fault  = slow;
            next_state.lamp.enable = slow;
            next_state.lamp.safe   = slow;
        end else if (pending) begin
            next_state.lamp.fault  = 1'b1;
            next_state.lamp.enable = 1'b0;
            next_state.lamp.safe   = 1'b0;
        end else begin
            next_state.lamp.fault  = 1'b0;
            next_state.lamp.enable = enable_valid_in;
            next_state.lamp.safe   = safe_on;
        end

        // Bus diagnostics
        next_state.perr = out_overload_in || sensor_overload_in;
        next_state.in_data[2:0] = sensor_overload_in ? 3'h0 :
                                  std_input_in;
        next_state.in_data[3] = pending || device_error_in;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= '0;
            state.std_out_bits <= SOD_STD_OUT_RESET;
            state.functional_switch_output_bit <= SOD_FSW_OUT_RESET;
            state.functional_switch_param <= SOD_FSW_PARAM_RESET;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    assign apb_out              = state.rsp;
    assign lamp_out             = state.lamp;
    assign safe_output_out      = state.safe_out;
    assign std_output_out       = state.std_out;
    assign slave_input_data_out = state.in_data;
    assign periph_error_out     = state.perr;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_aux_lamp;
        ce_in |=> lamp_out.aux == $past(aux_ok_in);
    endproperty
    a_aux_lamp: assert property (p_aux_lamp)
        else $error("aux lamp does not follow supply");

    property p_in_lamp;
        ce_in |=> lamp_out.in_lamp == $past(std_input_in);
    endproperty
    a_in_lamp: assert property (p_in_lamp)
        else $error("input lamp does not follow input");

    property p_out_lamp;
        lamp_out.out_lamp == std_output_out;
    endproperty
    a_out_lamp: assert property (p_out_lamp)
        else $error("output lamp differs from output");

    property p_normal_on;
        ce_in && normal && enable_valid_in && state.functional_switch_output_bit
        |=> safe_output_out && lamp_out.enable && lamp_out.safe
            && !lamp_out.fault;
    endproperty
    a_normal_on: assert property (p_normal_on)
        else $error("safe output not closed in normal operation");

    property p_follow_bit;
        ce_in && normal && enable_valid_in && !state.functional_switch_param
        && !state.functional_switch_output_bit
        |=> !safe_output_out && lamp_out.enable && !lamp_out.safe;
    endproperty
    a_follow_bit: assert property (p_follow_bit)
        else $error("safe output closed although output bit is off");

    property p_param_deact;
        ce_in && normal && enable_valid_in && state.functional_switch_param
        |=> safe_output_out;
    endproperty
    a_param_deact: assert property (p_param_deact)
        else $error("deactivated switching did not close output");

    property p_no_enable;
        ce_in && !enable_valid_in && addr_run_in && !device_error_in
        && !pending |=> !safe_output_out && !lamp_out.fault
            && !lamp_out.enable && !lamp_out.safe;
    endproperty
    a_no_enable: assert property (p_no_enable)
        else $error("safe path active without enable");

    sequence s_fault_start;
        ce_in && comm_fault_in;
    endsequence
    property p_fault_hold;
        s_fault_start ##1 ce_in |=> !safe_output_out && $past(pending);
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("communication fault did not open output");

    property p_ack_bit;
        ce_in && pending |=> slave_input_data_out[3] && !safe_output_out;
    endproperty
    a_ack_bit: assert property (p_ack_bit)
        else $error("acknowledgment request bit not raised");

    property p_unison;
        ce_in && device_error_in |=> lamp_out.fault == lamp_out.enable
            && lamp_out.enable == lamp_out.safe && !safe_output_out;
    endproperty
    a_unison: assert property (p_unison)
        else $error("device error lamps not in unison");

    property p_selector;
        ce_in && !addr_run_in && !device_error_in
        |=> lamp_out.fault == lamp_out.safe && !safe_output_out;
    endproperty
    a_selector: assert property (p_selector)
        else $error("selector indication wrong");

    property p_perr;
        ce_in |=> periph_error_out ==
            ($past(out_overload_in) || $past(sensor_overload_in));
    endproperty
    a_perr: assert property (p_perr)
        else $error("peripheral error flag wrong");

    property p_zero_inputs;
        ce_in && sensor_overload_in |=> slave_input_data_out[2:0] == 3'h0;
    endproperty
    a_zero_inputs: assert property (p_zero_inputs)
        else $error("inputs not zero during sensor overload");

    sequence s_apb_setup;
        ce_in && apb_in.psel && !apb_in.penable;
    endsequence
    property p_apb_ready;
        s_apb_setup |=> apb_out.pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("no ready after setup");

endmodule : sod_diag

// File: hdl/sod_fault_track.sv
// Communication fault latch, duration classing and acknowledgment
`timescale 1ns/1ns
module sod_fault_track
    import sod_pkg::*;
#(
    parameter int LONG_CYCLES = 32'(SOD_LONG_FAULT_CYCLES)
) (
    // Clock and control
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    // Fault and help signals
    input  wire logic comm_fault_in,
    input  wire logic help_reset_in,
    input  wire logic help_restart_in,
    // Status
    output logic      pending_out,
    output logic      need_reset_out
);

    typedef struct packed {
        logic [31:0] cnt;
        logic        pending;
        logic        long_fault;
    } sod_track_state_type;

    sod_track_state_type state;
    sod_track_state_type next_state;

    always_comb begin
        next_state = state;
        if (comm_fault_in) begin
            // A fault beats any help signal in the same cycle
            next_state.pending = 1'b1;
            if (state.cnt != 32'hFFFFFFFF) begin
                next_state.cnt = state.cnt + 32'h1;
            end
            if (state.cnt >= 32'(LONG_CYCLES)) begin
                next_state.long_fault = 1'b1;
            end
        end else if (state.pending) begin
            if ((state.long_fault && help_reset_in) ||
                (!state.long_fault && help_restart_in)) begin
                next_state = '0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    assign pending_out    = state.pending;
    assign need_reset_out = state.long_fault;

endmodule : sod_fault_track

// File: hdl/sod_flash.sv
// Slow and rapid flash clocks for the safe status lamps
`timescale 1ns/1ns
module sod_flash
    import sod_pkg::*;
#(
    parameter int SLOW_HALF = 32'(SOD_SLOW_FLASH_CYCLES),
    parameter int FAST_HALF = 32'(SOD_FAST_FLASH_CYCLES)
) (
    // Clock and control
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    // Flash phases
    output logic      slow_out,
    output logic      fast_out
);

    typedef struct packed {
        logic [31:0] slow_cnt;
        logic [31:0] fast_cnt;
        logic        slow;
        logic        fast;
    } sod_flash_state_type;

    sod_flash_state_type state;
    sod_flash_state_type next_state;

    always_comb begin
        next_state = state;
        if (state.slow_cnt >= 32'(SLOW_HALF - 1)) begin
            next_state.slow_cnt = 32'h0;
            next_state.slow     = ~state.slow;
        end else begin
            next_state.slow_cnt = state.slow_cnt + 32'h1;
        end
        if (state.fast_cnt >= 32'(FAST_HALF - 1)) begin
            next_state.fast_cnt = 32'h0;
            next_state.fast     = ~state.fast;
        end else begin
            next_state.fast_cnt = state.fast_cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    assign slow_out = state.slow;
    assign fast_out = state.fast;

endmodule : sod_flash

// File: hdl/sod_pkg.sv
// Shared constants and carrier types for the safe output slave diagnostics
package sod_pkg;

    // Register map (byte addresses)
    localparam logic [11:0] SOD_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] SOD_STATUS_ADDR = 12'h004;

    // Control register fields
    localparam int SOD_CTRL_STD_OUT_LSB = 0;
    localparam int SOD_CTRL_FSW_OUT_BIT = 2;
    localparam int SOD_CTRL_FSW_PARAM   = 3;
    localparam logic [1:0] SOD_STD_OUT_RESET   = 2'h0;
    localparam logic       SOD_FSW_OUT_RESET   = 1'h0;
    localparam logic       SOD_FSW_PARAM_RESET = 1'h1;

    // Status register fields
    localparam int SOD_STAT_INPUT_LSB = 0;
    localparam int SOD_STAT_FOURTH    = 3;
    localparam int SOD_STAT_PERR      = 4;
    localparam int SOD_STAT_PENDING   = 5;
    localparam int SOD_STAT_NEED_RST  = 6;
    localparam int SOD_STAT_SAFE_OUT  = 7;
    localparam int SOD_STAT_AUX_OK    = 8;

    // Timing
    localparam longint SOD_CLK_HZ       = 125_000_000;
    localparam longint SOD_LONG_FAULT_MS = 140;
    localparam longint SOD_LONG_FAULT_CYCLES =
        (SOD_LONG_FAULT_MS * SOD_CLK_HZ) / 1000;
    localparam longint SOD_SLOW_FLASH_MS = 500;
    localparam longint SOD_SLOW_FLASH_CYCLES =
        (SOD_SLOW_FLASH_MS * SOD_CLK_HZ) / 1000;
    localparam longint SOD_FAST_FLASH_MS = 100;
    localparam longint SOD_FAST_FLASH_CYCLES =
        (SOD_FAST_FLASH_MS * SOD_CLK_HZ) / 1000;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sod_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sod_apb_rsp_type;

    typedef struct packed {
        logic       aux;
        logic [2:0] in_lamp;
        logic [1:0] out_lamp;
        logic       fault;
        logic       enable;
        logic       safe;
    } sod_lamp_type;

endpackage : sod_pkg

// File: test/sod_monitor_model.sv
// Behavioural safety monitor: safe enable, fault bursts, help signals
`timescale 1ns/1ns
module sod_monitor_model #(
    parameter int LONG_CYCLES = 20
) (
    // Clock
    input  wire logic clk_in,
    // Safe link towards the slave
    output logic      enable_valid_out,
    output logic      comm_fault_out,
    output logic      help_reset_out,
    output logic      help_restart_out
);
    int last_len = 0;

    initial begin
        enable_valid_out = 1'b0;
        comm_fault_out = 1'b0;
        help_reset_out = 1'b0;
        help_restart_out = 1'b0;
    end

    // Called just after a rising edge
    task automatic set_enable(input logic v);
        enable_valid_out <= v;
    endtask : set_enable

    // Fault burst; an early restart inside it must be ignored
    task automatic shutdown(input int len, input logic early);
        last_len = len;
        @(posedge clk_in);
        comm_fault_out <= 1'b1;
        for (int i = 0; i < len; i++) begin
            @(posedge clk_in);
            help_restart_out <= early && (i == 1);
        end
        comm_fault_out <= 1'b0;
        help_restart_out <= 1'b0;
    endtask : shutdown

    // Help pulse only after the fault has ended, after an idle gap
    task automatic ack(input logic wrong, input int gap);
        logic lng;
        lng = (last_len > LONG_CYCLES) ^ wrong;
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        help_reset_out <= lng;
        help_restart_out <= !lng;
        @(posedge clk_in);
        help_reset_out <= 1'b0;
        help_restart_out <= 1'b0;
    endtask : ack
endmodule : sod_monitor_model

// File: test/test_safe_output_slave_diagnostics.sv
// Self-checking bench for the safe output slave diagnostics
`timescale 1ns/1ns
module test_safe_output_slave_diagnostics;
    import sod_pkg::*;
    localparam int LONG = 20;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    sod_apb_req_type req = '0;
    sod_apb_rsp_type rsp;
    sod_lamp_type    lamp;
    logic            aux = 1'b0;
    logic            sov = 1'b0;
    logic            oov = 1'b0;
    logic            run = 1'b1;
    logic            derr = 1'b0;
    logic            ce = 1'b1;
    logic [2:0]      sin = 3'h0;
    logic            en, flt, hrs, hrt, safe, perr, err;
    logic [1:0]      sout;
    logic [3:0]      data, c;
    logic [31:0]     rd, v;
    logic [31:0]     seed = 32'h2EAE;
    int              slow, fast;
    int              fail_count = 0;
    int              n_checks = 0;

    sod_monitor_model #(.LONG_CYCLES(LONG)) mon (
        .clk_in(clk), .enable_valid_out(en), .comm_fault_out(flt),
        .help_reset_out(hrs), .help_restart_out(hrt));

    sod_diag #(.LONG_CYCLES(LONG), .SLOW_HALF(4), .FAST_HALF(2)) dut (
        .clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
        .apb_in(req), .apb_out(rsp), .aux_ok_in(aux),
        .std_input_in(sin), .enable_valid_in(en), .comm_fault_in(flt),
        .help_reset_in(hrs), .help_restart_in(hrt), .addr_run_in(run),
        .device_error_in(derr), .out_overload_in(oov),
        .sensor_overload_in(sov), .lamp_out(lamp),
        .safe_output_out(safe), .std_output_out(sout),
        .slave_input_data_out(data), .periph_error_out(perr));

    initial begin
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction : lfsr

    function automatic logic [2:0] rep_in(input logic [2:0] s,
                                          input logic ov);
        return ov ? 3'h0 : s;
    endfunction : rep_in

    function automatic logic fsafe(input logic e, input logic [3:0] k);
        return e & (k[3] | k[2]);
    endfunction : fsafe

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_n

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50)
            fail_count++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic fault_case(input int len);
        mon.shutdown(len, 1'b1);
        wait_n(2);
        chk("fault safe", {safe, data[3]}, 2'b01);
        chk("fault lamps", {lamp.fault, lamp.enable, lamp.safe}, 3'h4);
        apb(1'b0, SOD_STATUS_ADDR, '0);
        chk("fault class", rd[6:5], {len > LONG, 1'b1});
        mon.ack(1'b1, 1);
        wait_n(3);
        chk("wrong help", {safe, data[3]}, 2'b01);
        mon.ack(1'b0, 5);
        wait_n(3);
        chk("after ack", {safe, data[3]}, 2'b10);
        chk("ack lamps", {lamp.fault, lamp.enable, lamp.safe}, 3'h3);
    endtask : fault_case

    // Counts fault lamp toggles while checking the three lamps agree
    task automatic flash_count(output int n);
        logic p;
        n = 0;
        p = lamp.fault;
        repeat (24) begin
            @(posedge clk);
            #1;
            chk("unison", lamp.fault === lamp.enable &&
                lamp.enable === lamp.safe, 1'b1);
            if (lamp.fault !== p)
                n++;
            p = lamp.fault;
        end
    endtask : flash_count

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("reset outputs", {rsp.pready, safe, perr, data, lamp}, '0);
        apb(1'b0, SOD_CTRL_ADDR, '0);
        chk("ctrl reset", rd, 32'h8);
        apb(1'b0, 12'h0FC, '0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, SOD_STATUS_ADDR, 32'hFFFF_FFFF);
        chk("status write err", {31'h0, err}, 32'h0);
        apb(1'b0, SOD_CTRL_ADDR, '0);
        chk("ctrl kept err", {31'h0, err}, 32'h0);
        chk("ctrl kept", rd, 32'h8);
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 32'h7FF : (i == 1) ? 32'h404 : seed;
            c = v[3:0];
            apb(1'b1, SOD_CTRL_ADDR, {28'h0, c});
            @(posedge clk);
            aux <= v[4];
            sin <= v[7:5];
            sov <= v[8];
            oov <= v[9];
            mon.set_enable(v[10]);
            wait_n(3);
            chk("aux lamp", lamp.aux, v[4]);
            chk("input lamps", lamp.in_lamp, v[7:5]);
            chk("outputs", {lamp.out_lamp, sout},
                {2{c[1:0] & ~{2{v[9]}}}});
            chk("safe out", safe, fsafe(v[10], c));
            chk("safe lamps", {lamp.fault, lamp.enable, lamp.safe},
                {1'b0, v[10], fsafe(v[10], c)});
            chk("data", data, {1'b0, rep_in(v[7:5], v[8])});
            chk("perr", perr, v[8] | v[9]);
            apb(1'b0, SOD_STATUS_ADDR, '0);
            chk("status", {err, rd[8:0]}, {1'b0, v[4], fsafe(v[10], c),
                2'b00, v[8] | v[9], 1'b0,
                rep_in(v[7:5], v[8])});
        end
        apb(1'b1, SOD_CTRL_ADDR, 32'h8);
        @(posedge clk);
        mon.set_enable(1'b1);
        fault_case(5);
        fault_case(30);
        fault_case(LONG);
        fault_case(LONG + 1);
        @(posedge clk);
        run <= 1'b0;
        wait_n(3);
        chk("selector safe", safe, 1'b0);
        flash_count(slow);
        @(posedge clk);
        run <= 1'b1;
        derr <= 1'b1;
        wait_n(3);
        chk("error data", data[3], 1'b1);
        flash_count(fast);
        chk("slow flashes", slow > 0, 1'b1);
        chk("rapid flash", fast > slow, 1'b1);
        @(posedge clk);
        ce <= 1'b0;
        derr <= 1'b0;
        wait_n(4);
        chk("frozen data", data[3], 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        wait_n(3);
        chk("resumed data", data[3], 1'b0);
        final_report();
    end
endmodule : test_safe_output_slave_diagnostics
